// ### mmp_pkg.sv
package mmp_pkg;
  // Data space boundaries
  localparam logic [7:0]  MMP_LOW_TOP       = 8'h7f;
  localparam logic [7:0]  MMP_BANK_TOP      = 8'h1f;
  localparam logic [7:0]  MMP_BIT_BASE      = 8'h20;
  localparam logic [7:0]  MMP_BIT_AREA_LAST = 8'h7f;
  localparam int          MMP_IRAM_BYTES    = 256;
  localparam int          MMP_ONCHIP_EXTERNAL_RAM_BYTES    = 4096;
  localparam int          MMP_ONCHIP_EXTERNAL_RAM_AW       = 12;
  // Stack pointer reset value
  localparam logic [7:0]  MMP_SP_RESET      = 8'h07;
  // Page values
  localparam logic [7:0]  MMP_PAGE_ZERO     = 8'h00;
  localparam logic [7:0]  MMP_PAGE_CAN      = 8'h0c;
  localparam logic [7:0]  MMP_PAGE_CFG      = 8'h0f;
  localparam logic [7:0]  MMP_PAGE_RESET    = 8'h00;
  localparam logic        MMP_AUTOPG_RESET  = 1'b1;
  // Page-stack, stack pointer and status register addresses in the special register space
  localparam logic [7:0]  MMP_ADDR_PAGESEL  = 8'ha7;
  localparam logic [7:0]  MMP_ADDR_PGCTRL   = 8'h84;
  localparam logic [7:0]  MMP_ADDR_NEXT     = 8'h85;
  localparam logic [7:0]  MMP_ADDR_LAST     = 8'h86;
  localparam logic [7:0]  MMP_ADDR_SP       = 8'h81;
  localparam logic [7:0]  MMP_ADDR_STATUS   = 8'hd0;
  // Program status word bank-select positions
  localparam int          MMP_BANK_SEL_LO   = 3;
  localparam int          MMP_BANK_SEL_HI   = 4;
  // Lock byte addresses
  localparam logic [15:0] MMP_LOCK_LARGE    = 16'hfbff;
  localparam logic [15:0] MMP_LOCK_SMALL    = 16'h7fff;

  // Kind of data access requested by the core
  typedef enum logic [1:0] {
    MMP_ACC_DIRECT,
    MMP_ACC_INDIRECT,
    MMP_ACC_REG,
    MMP_ACC_BIT
  } mmp_acc_e;

  // One data-space request from the core
  typedef struct packed {
    logic       valid;
    logic       write;
    mmp_acc_e   kind;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wbit;
  } mmp_req_s;

  // Routing decision
  typedef struct packed {
    logic       to_iram;
    logic       to_sfr;
    logic [7:0] iram_addr;
    logic [2:0] bit_pos;
    logic       is_bit;
  } mmp_route_s;
endpackage

// ### mmp_ram.sv
`timescale 1ns/1ps
module mmp_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          core_clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  // Storage array
  logic [7:0] mem_reg [DEPTH];

  // Write port
  always_ff @(posedge core_clk) begin
    if (ce && we) begin
      mem_reg[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk) begin
    if (ce) begin
      rdata <= mem_reg[addr];
    end
  end
endmodule

// ### mmp_decode.sv
`timescale 1ns/1ps
module mmp_decode (
  input  mmp_pkg::mmp_req_s   req,
  input  wire logic [1:0]     bank_sel,
  input  wire logic [7:0]     ptr_value,
  output mmp_pkg::mmp_route_s route
);
  import mmp_pkg::*;

  // Address routing by access kind
  always_comb begin
    route           = '0;
    route.is_bit    = (req.kind == MMP_ACC_BIT);
    case (req.kind)
      MMP_ACC_REG: begin
        // Bank register in active bank
        route.to_iram   = 1'b1;
        route.iram_addr = {3'b000, bank_sel, req.addr[2:0]};
      end
      MMP_ACC_INDIRECT: begin
        // Pointer contents reach whole 256 bytes
        route.to_iram   = 1'b1;
        route.iram_addr = ptr_value;
      end
      MMP_ACC_DIRECT: begin
        if (req.addr <= MMP_LOW_TOP) begin
          route.to_iram   = 1'b1;
          route.iram_addr = req.addr;
        end else begin
          route.to_sfr    = 1'b1;
          route.iram_addr = req.addr;
        end
      end
      MMP_ACC_BIT: begin
        if (req.addr <= MMP_BIT_AREA_LAST) begin
          // Byte = base + bitaddr/8
          route.to_iram   = 1'b1;
          route.iram_addr = MMP_BIT_BASE + {4'h0, req.addr[6:3]};
        end else begin
          // Special register byte ending 0x0/0x8
          route.to_sfr    = 1'b1;
          route.iram_addr = {req.addr[7:3], 3'b000};
        end
        route.bit_pos = req.addr[2:0];
      end
      default: begin
        route = '0;
      end
    endcase
  end
endmodule

// ### mmp_memory_map.sv
`timescale 1ns/1ps
module mmp_memory_map #(
  parameter int          ONCHIP_EXTERNAL_RAM_BYTES = mmp_pkg::MMP_ONCHIP_EXTERNAL_RAM_BYTES,
  parameter int          ONCHIP_EXTERNAL_RAM_AW    = mmp_pkg::MMP_ONCHIP_EXTERNAL_RAM_AW,
  parameter logic        LARGE_FLASH = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // Data-space request from the core
  input  mmp_pkg::mmp_req_s      req,
  output logic      [7:0]        rdata,
  output logic                   rbit,
  output logic                   rvalid,
  // Routed special register access for peripherals
  output logic                   sfr_sel,
  output logic                   sfr_write,
  output logic      [7:0]        sfr_addr,
  output logic      [7:0]        sfr_page,
  output logic                   sfr_bit_ok,
  input  wire logic [7:0]        sfr_rdata,
  input  wire logic              sfr_all_pages,
  // Stack operations
  input  wire logic              push_req,
  input  wire logic              pop_req,
  input  wire logic [7:0]        push_data,
  output logic      [7:0]        stack_top_pointer,
  // Program status word bank bits
  input  wire logic [1:0]        bank_select,
  // Interrupt vector and return
  input  wire logic              vector_accept,
  input  wire logic              vector_is_can,
  input  wire logic              return_accept,
  // External move and code move
  input  wire logic              xmove_valid,
  input  wire logic              xmove_write,
  input  wire logic              xmove_flash_wr,
  input  wire logic [ONCHIP_EXTERNAL_RAM_AW-1:0] xmove_addr,
  input  wire logic [7:0]        xmove_wdata,
  output logic      [7:0]        xmove_rdata,
  output logic                   flash_wr_req,
  input  wire logic              code_move_valid,
  input  wire logic [15:0]       code_addr,
  output logic                   flash_rd_req,
  output logic                   lock_byte_hit,
  // Page state seen by the core
  output logic      [7:0]        page_select_reg,
  output logic      [7:0]        page_stack_second,
  output logic      [7:0]        page_stack_bottom,
  output logic                   auto_page_enable
);
  import mmp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  sp_reg;              // Stack top pointer
  logic [7:0]  ptr_reg;             // Latched pointer contents
  logic [1:0]  ptr_phase_reg;       // Pointer fetch step
  mmp_route_s  route;               // Decode result
  logic        iram_we;             // Internal RAM write
  logic [7:0]  iram_addr;           // Internal RAM address
  logic [7:0]  iram_wdata;          // Internal RAM write data
  logic [7:0]  iram_rdata;          // Internal RAM read data
  logic        sfr_pg_hit;          // Page-stack register selected
  logic        rd_pend_reg;         // Read answer pending
  logic        rd_sfr_reg;          // Answer from register space
  logic        rd_is_bit_reg;       // Answer is a bit
  logic [2:0]  rd_pos_reg;          // Bit position of answer
  logic [7:0]  rd_local_reg;        // Local register read value
  logic        rd_local_sel_reg;    // Answer from local register
  logic        onchip_external_ram_we;             // External RAM write
  logic        page_wr;             // Software writes page select
  logic        next_wr;             // Software writes second byte
  logic        last_wr;             // Software writes bottom byte
  logic        ctrl_wr;             // Software writes control

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  mmp_decode u_decode (
    .req       (req),
    .bank_sel  (bank_select),
    .ptr_value (ptr_reg),
    .route     (route)
  );

  // Internal RAM port: push has priority, then pop, then request
  always_comb begin
    iram_we    = 1'b0;
    iram_addr  = route.iram_addr;
    iram_wdata = req.wdata;
    if (push_req) begin
      iram_we    = 1'b1;
      iram_addr  = sp_reg + 8'h01;
      iram_wdata = push_data;
    end else if (pop_req) begin
      iram_addr  = sp_reg;
    end else if (req.valid && req.kind == MMP_ACC_INDIRECT && ptr_phase_reg == 2'd0) begin
      // Fetch pointer register of active bank
      iram_addr  = {3'b000, bank_select, 2'b00, req.addr[0]};
    end else if (req.valid && route.to_iram) begin
      // Indirect write waits for the fresh pointer; a stale one hits the wrong byte
      iram_we    = req.write && !route.is_bit &&
                   (req.kind != MMP_ACC_INDIRECT || ptr_phase_reg == 2'd2);
      // Bit write handled as read-modify-write by the core
    end
  end

  // Internal RAM, 256 bytes
  mmp_ram #(
    .DEPTH (MMP_IRAM_BYTES),
    .AW    (8)
  ) u_iram (
    .core_clk (core_clk),
    .ce       (ce),
    .we       (iram_we),
    .addr     (iram_addr),
    .wdata    (iram_wdata),
    .rdata    (iram_rdata)
  );

  // Indirect pointer fetch sequence
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ptr_phase_reg <= 2'd0;
      ptr_reg       <= 8'h00;
    end else if (ce) begin
      if (req.valid && req.kind == MMP_ACC_INDIRECT && !push_req && !pop_req) begin
        case (ptr_phase_reg)
          2'd0: ptr_phase_reg <= 2'd1;
          2'd1: begin
            ptr_reg       <= iram_rdata;
            ptr_phase_reg <= 2'd2;
          end
          default: ptr_phase_reg <= 2'd0;
        endcase
      end else begin
        ptr_phase_reg <= 2'd0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack pointer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sp_reg <= MMP_SP_RESET;
    end else if (ce) begin
      if (push_req) begin
        sp_reg <= sp_reg + 8'h01;
      end else if (pop_req) begin
        sp_reg <= sp_reg - 8'h01;
      end else if (req.valid && req.write && route.to_sfr && !route.is_bit && req.addr == MMP_ADDR_SP) begin
        sp_reg <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special register routing
  always_comb begin
    // Byte address, so a bit address never aliases a local register
    sfr_pg_hit = (route.iram_addr == MMP_ADDR_PAGESEL) ||
                 (page_select_reg == MMP_PAGE_CFG &&
                  (route.iram_addr == MMP_ADDR_PGCTRL || route.iram_addr == MMP_ADDR_NEXT ||
                   route.iram_addr == MMP_ADDR_LAST));
    // Stack top pointer answers locally, never on the peripheral bus
    sfr_sel    = req.valid && route.to_sfr && !sfr_pg_hit && route.iram_addr != MMP_ADDR_SP &&
                 ptr_phase_reg == 2'd0;
    sfr_write  = req.write;
    sfr_addr   = route.iram_addr;
    sfr_page   = page_select_reg;
    sfr_bit_ok = route.is_bit && (route.iram_addr[2:0] == 3'b000);
    page_wr    = req.valid && req.write && route.to_sfr && !route.is_bit && req.addr == MMP_ADDR_PAGESEL;
    ctrl_wr    = req.valid && req.write && route.to_sfr && !route.is_bit && sfr_pg_hit && req.addr == MMP_ADDR_PGCTRL;
    next_wr    = req.valid && req.write && route.to_sfr && !route.is_bit && sfr_pg_hit && req.addr == MMP_ADDR_NEXT;
    last_wr    = req.valid && req.write && route.to_sfr && !route.is_bit && sfr_pg_hit && req.addr == MMP_ADDR_LAST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page stack
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      page_select_reg   <= MMP_PAGE_RESET;
      page_stack_second <= MMP_PAGE_RESET;
      page_stack_bottom <= MMP_PAGE_RESET;
    end else if (ce) begin
      if (vector_accept && auto_page_enable) begin
        page_stack_bottom <= page_stack_second;
        page_stack_second <= page_select_reg;
        page_select_reg   <= vector_is_can ? MMP_PAGE_CAN : MMP_PAGE_ZERO;
      end else if (return_accept && auto_page_enable) begin
        page_select_reg   <= page_stack_second;
        page_stack_second <= page_stack_bottom;
        page_stack_bottom <= MMP_PAGE_ZERO;
      end else begin
        // Plain writes touch only their own byte
        if (page_wr) page_select_reg <= req.wdata;
        if (next_wr) page_stack_second <= req.wdata;
        if (last_wr) page_stack_bottom <= req.wdata;
      end
    end
  end

  // Auto page enable control
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      auto_page_enable <= MMP_AUTOPG_RESET;
    end else if (ce && ctrl_wr) begin
      auto_page_enable <= req.wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_pend_reg      <= 1'b0;
      rd_sfr_reg       <= 1'b0;
      rd_is_bit_reg    <= 1'b0;
      rd_pos_reg       <= 3'd0;
      rd_local_reg     <= 8'h00;
      rd_local_sel_reg <= 1'b0;
    end else if (ce) begin
      rd_pend_reg   <= req.valid && !req.write && !push_req && !pop_req &&
                       (req.kind != MMP_ACC_INDIRECT || ptr_phase_reg == 2'd2);
      rd_sfr_reg    <= route.to_sfr;
      rd_is_bit_reg <= route.is_bit;
      rd_pos_reg    <= route.bit_pos;
      // Local registers keyed by byte address, never by a bit address
      rd_local_sel_reg <= route.to_sfr && (sfr_pg_hit || route.iram_addr == MMP_ADDR_SP);
      case (route.iram_addr)
        MMP_ADDR_PAGESEL: rd_local_reg <= page_select_reg;
        MMP_ADDR_PGCTRL:  rd_local_reg <= {7'h00, auto_page_enable};
        MMP_ADDR_NEXT:    rd_local_reg <= page_stack_second;
        MMP_ADDR_LAST:    rd_local_reg <= page_stack_bottom;
        MMP_ADDR_SP:      rd_local_reg <= sp_reg;
        default:          rd_local_reg <= 8'h00;
      endcase
    end
  end

  // Answer selection
  always_comb begin
    rvalid = rd_pend_reg;
    if (rd_local_sel_reg) begin
      rdata = rd_local_reg;
    end else if (rd_sfr_reg) begin
      rdata = sfr_all_pages || 1'b1 ? sfr_rdata : 8'h00;
    end else begin
      rdata = iram_rdata;
    end
    rbit = rd_is_bit_reg ? rdata[rd_pos_reg] : 1'b0;
  end

  assign stack_top_pointer = sp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // External RAM and flash steering
  assign onchip_external_ram_we      = xmove_valid && xmove_write && !xmove_flash_wr;
  assign flash_wr_req = xmove_valid && xmove_write && xmove_flash_wr;
  assign flash_rd_req = code_move_valid;
  assign lock_byte_hit = code_move_valid &&
                         (code_addr == (LARGE_FLASH ? MMP_LOCK_LARGE : MMP_LOCK_SMALL));

  // On-chip external RAM
  mmp_ram #(
    .DEPTH (ONCHIP_EXTERNAL_RAM_BYTES),
    .AW    (ONCHIP_EXTERNAL_RAM_AW)
  ) u_onchip_external_ram (
    .core_clk (core_clk),
    .ce       (ce),
    .we       (onchip_external_ram_we),
    .addr     (xmove_addr),
    .wdata    (xmove_wdata),
    .rdata    (xmove_rdata)
  );
endmodule

// ### mmp_memory_map_sva.sv
`timescale 1ns/1ps
module mmp_memory_map_sva
  import mmp_pkg::*;
#(
  parameter logic LARGE_FLASH = 1'b1
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        ce,
  input mmp_pkg::mmp_req_s req,
  input wire logic        sfr_sel,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_page,
  input wire logic        sfr_bit_ok,
  input wire logic        push_req,
  input wire logic        pop_req,
  input wire logic [7:0]  stack_top_pointer,
  input wire logic        vector_accept,
  input wire logic        vector_is_can,
  input wire logic        return_accept,
  input wire logic        xmove_valid,
  input wire logic        xmove_write,
  input wire logic        xmove_flash_wr,
  input wire logic        flash_wr_req,
  input wire logic        code_move_valid,
  input wire logic [15:0] code_addr,
  input wire logic        flash_rd_req,
  input wire logic        lock_byte_hit,
  input wire logic [7:0]  page_select_reg,
  input wire logic [7:0]  page_stack_second,
  input wire logic [7:0]  page_stack_bottom,
  input wire logic        auto_page_enable
);
  // One clock domain, one reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Page stack
  vec_push_a: assert property (ce && vector_accept && auto_page_enable |=>
    page_select_reg == ($past(vector_is_can) ? MMP_PAGE_CAN : MMP_PAGE_ZERO) &&
    page_stack_second == $past(page_select_reg) && page_stack_bottom == $past(page_stack_second))
    else $error("page stack push wrong");
  ret_pop_a: assert property (ce && return_accept && !vector_accept && auto_page_enable |=>
    page_select_reg == $past(page_stack_second) && page_stack_second == $past(page_stack_bottom) &&
    page_stack_bottom == 8'h00)
    else $error("page stack pop wrong");
  auto_off_a: assert property (ce && !auto_page_enable && (vector_accept || return_accept) |=>
    $stable(page_select_reg) && $stable(page_stack_second) && $stable(page_stack_bottom))
    else $error("page stack moved while disabled");
  reset_state_a: assert property ($rose(rstn) |-> stack_top_pointer == MMP_SP_RESET &&
    page_select_reg == MMP_PAGE_RESET && page_stack_bottom == 8'h00 && auto_page_enable)
    else $error("reset state wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Stack and routing
  push_sp_a: assert property (ce && push_req |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("stack pointer not incremented");
  direct_sfr_a: assert property (ce && req.valid && req.kind == MMP_ACC_DIRECT && req.addr == 8'h90 &&
    !push_req && !pop_req |-> sfr_sel && sfr_addr == 8'h90 && sfr_page == page_select_reg && !sfr_bit_ok)
    else $error("direct upper access not routed");
  indirect_ram_a: assert property (req.valid && (req.kind == MMP_ACC_INDIRECT || req.kind == MMP_ACC_REG)
    |-> !sfr_sel)
    else $error("indirect access reached registers");
  sfr_bit_a: assert property (ce && req.valid && req.kind == MMP_ACC_BIT && req.addr[7] &&
    !push_req && !pop_req |-> sfr_sel && sfr_bit_ok && sfr_addr == {req.addr[7:3], 3'b000})
    else $error("register bit access wrong");
  lock_hit_a: assert property (code_move_valid |-> flash_rd_req &&
    lock_byte_hit == (code_addr == (LARGE_FLASH ? MMP_LOCK_LARGE : MMP_LOCK_SMALL)))
    else $error("lock byte decode wrong");
  onchip_external_ram_wr_a: assert property (xmove_valid && xmove_write && !xmove_flash_wr |-> !flash_wr_req)
    else $error("external write reached flash");
endmodule
bind mmp_memory_map mmp_memory_map_sva #(.LARGE_FLASH(LARGE_FLASH)) chk_u (.*);

// ### mmp_core_model.sv
`timescale 1ns/1ps
module mmp_core_model (
  input  wire logic core_clk,
  output logic      vector_accept,
  output logic      vector_is_can,
  output logic      return_accept,
  output logic      push_req,
  output logic      pop_req,
  output logic [7:0] push_data
);
  // Idle core: no pulses, push data 0xa5
  initial begin
    {vector_accept, vector_is_can, return_accept, push_req, pop_req} = '0;
    push_data = 8'ha5;
  end
  // One-cycle pulse on one of the core strobes
  task automatic pulse(input logic [2:0] sel, input logic can, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {vector_accept, return_accept, push_req} = sel;
    vector_is_can = can;
    push_data = d;
    @(posedge core_clk);
    #1;
    {vector_accept, return_accept, push_req} = 3'b000;
    push_data = ~d;
  endtask
endmodule

// ### mmp_memory_map_tb.sv
`timescale 1ns/1ps
module mmp_memory_map_tb;
  import mmp_pkg::*;
  logic        core_clk, rstn, ce, rbit, rvalid, sfr_sel, sfr_write, sfr_bit_ok, sfr_all_pages;
  logic        push_req, pop_req, vector_accept, vector_is_can, return_accept, xmove_valid;
  logic        xmove_write, xmove_flash_wr, flash_wr_req, code_move_valid, flash_rd_req;
  logic        lock_byte_hit, auto_page_enable;
  logic [7:0]  rdata, sfr_addr, sfr_page, sfr_rdata, push_data, stack_top_pointer, xmove_wdata;
  logic [7:0]  xmove_rdata, page_select_reg, page_stack_second, page_stack_bottom, d;
  logic [11:0] xmove_addr;
  logic [15:0] code_addr;
  logic [1:0]  bank_select;
  logic [8:0]  e;
  logic [8:0]  exp_q[$];
  mmp_req_s    req;
  int          mismatches, samples_checked;
  mmp_memory_map dut_u (.*);
  mmp_core_model core_u (.*);
  // Clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic pg(input logic [7:0] p, input logic [7:0] s, input logic [7:0] b);
    chk(page_select_reg, p);
    chk(page_stack_second, s);
    chk(page_stack_bottom, b);
  endtask
  // Read answers taken in order, bit 8 marks a bit result
  always @(negedge core_clk) begin
    if (rvalid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1xx;
      if (e[8]) chk({7'h00, rbit}, {7'h00, e[0]});
      else chk(rdata, e[7:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Data-space request held for n edges
  task automatic acc(input logic w, input mmp_acc_e k, input logic [7:0] a, input logic [7:0] v, input int n);
    @(posedge core_clk);
    #1;
    req = '{valid: 1'b1, write: w, kind: k, addr: a, wdata: v, wbit: 1'b0};
    repeat (n) @(posedge core_clk);
    #1;
    req.valid = 1'b0;
  endtask
  task automatic rd(input mmp_acc_e k, input logic [7:0] a, input logic [8:0] x, input int n);
    exp_q.push_back(x);
    acc(1'b0, k, a, 8'h00, n);
  endtask
  // External move, one cycle
  task automatic xm(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    {xmove_valid, xmove_write, xmove_addr, xmove_wdata} = {1'b1, w, a, v};
    #1;
    chk({7'h00, flash_wr_req}, {7'h00, w & xmove_flash_wr});
    @(posedge core_clk);
    #1;
    xmove_valid = 1'b0;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; only occupied addresses, page written after RAM, bank and bit tests
  initial begin
    d = 8'($urandom(32'hcacf));
    {rstn, ce, sfr_all_pages, xmove_valid, xmove_write, xmove_flash_wr, code_move_valid} = 7'b0100000;
    {req, bank_select, xmove_addr, xmove_wdata, code_addr} = '0;
    sfr_rdata = 8'($urandom());
    repeat (5) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    pg(MMP_PAGE_RESET, 8'h00, 8'h00);
    chk(stack_top_pointer, MMP_SP_RESET);
    chk({7'h00, auto_page_enable}, 8'h01);
    acc(1'b1, MMP_ACC_DIRECT, 8'h30, d, 1);
    rd(MMP_ACC_DIRECT, 8'h30, {1'b0, d}, 1);
    acc(1'b1, MMP_ACC_DIRECT, 8'h01, 8'h30, 1);
    rd(MMP_ACC_INDIRECT, 8'h01, {1'b0, d}, 3);
    acc(1'b1, MMP_ACC_DIRECT, 8'h00, 8'h90, 1);
    acc(1'b1, MMP_ACC_INDIRECT, 8'h00, ~d, 3);
    rd(MMP_ACC_INDIRECT, 8'h00, {1'b0, ~d}, 3);
    rd(MMP_ACC_DIRECT, 8'h30, {1'b0, d}, 1);
    rd(MMP_ACC_DIRECT, 8'h90, {1'b0, sfr_rdata}, 1);
    fork
      acc(1'b1, MMP_ACC_DIRECT, 8'h90, d, 1);
      begin
        @(posedge core_clk);
        #2;
        chk({6'h00, sfr_sel, sfr_write}, 8'h03);
        chk(sfr_addr, 8'h90);
      end
    join
    acc(1'b1, MMP_ACC_DIRECT, 8'h11, d ^ 8'h5a, 1);
    bank_select = 2'b10;
    rd(MMP_ACC_REG, 8'h01, {1'b0, d ^ 8'h5a}, 1);
    bank_select = 2'b00;
    acc(1'b1, MMP_ACC_DIRECT, 8'h22, 8'h08, 1);
    acc(1'b1, MMP_ACC_DIRECT, 8'h13, 8'h00, 1);
    rd(MMP_ACC_BIT, 8'h13, 9'h101, 1);
    rd(MMP_ACC_BIT, 8'h12, 9'h100, 1);
    rd(MMP_ACC_DIRECT, 8'h13, 9'h000, 1);
    rd(MMP_ACC_BIT, 8'h8b, {8'h80, sfr_rdata[3]}, 1);
    core_u.pulse(3'b001, 1'b0, d);
    chk(stack_top_pointer, 8'h08);
    rd(MMP_ACC_DIRECT, 8'h08, {1'b0, d}, 1);
    acc(1'b1, MMP_ACC_DIRECT, MMP_ADDR_PAGESEL, MMP_PAGE_CFG, 1);
    rd(MMP_ACC_BIT, MMP_ADDR_PAGESEL, {8'h80, sfr_rdata[7]}, 1);
    rd(MMP_ACC_DIRECT, MMP_ADDR_PAGESEL, {1'b0, MMP_PAGE_CFG}, 1);
    acc(1'b1, MMP_ACC_DIRECT, MMP_ADDR_LAST, 8'h55, 1);
    rd(MMP_ACC_DIRECT, MMP_ADDR_LAST, 9'h055, 1);
    pg(MMP_PAGE_CFG, 8'h00, 8'h55);
    core_u.pulse(3'b100, 1'b1, d);
    pg(MMP_PAGE_CAN, MMP_PAGE_CFG, 8'h00);
    core_u.pulse(3'b100, 1'b0, d);
    pg(MMP_PAGE_ZERO, MMP_PAGE_CAN, MMP_PAGE_CFG);
    core_u.pulse(3'b010, 1'b0, d);
    pg(MMP_PAGE_CAN, MMP_PAGE_CFG, 8'h00);
    core_u.pulse(3'b010, 1'b0, d);
    pg(MMP_PAGE_CFG, 8'h00, 8'h00);
    acc(1'b1, MMP_ACC_DIRECT, MMP_ADDR_PGCTRL, 8'h00, 1);
    chk({7'h00, auto_page_enable}, 8'h00);
    core_u.pulse(3'b100, 1'b1, d);
    pg(MMP_PAGE_CFG, 8'h00, 8'h00);
    acc(1'b1, MMP_ACC_DIRECT, MMP_ADDR_PGCTRL, 8'h01, 1);
    chk({7'h00, auto_page_enable}, 8'h01);
    ce = 1'b0;
    core_u.pulse(3'b100, 1'b1, d);
    pg(MMP_PAGE_CFG, 8'h00, 8'h00);
    ce = 1'b1;
    xm(1'b1, 12'hfff, d);
    xm(1'b1, 12'h000, ~d);
    xmove_flash_wr = 1'b1;
    xm(1'b1, 12'hfff, ~d);
    xmove_flash_wr = 1'b0;
    xm(1'b0, 12'hfff, 8'h00);
    chk(xmove_rdata, d);
    foreach (exp_q[i]) code_addr = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #1;
      code_addr = (i == 0) ? MMP_LOCK_LARGE : ((i == 1) ? 16'hfbfe : MMP_LOCK_SMALL);
      code_move_valid = 1'b1;
      #5;
      chk({6'h00, flash_rd_req, lock_byte_hit}, {6'h00, 1'b1, i == 0});
    end
    code_move_valid = 1'b0;
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    pg(MMP_PAGE_RESET, 8'h00, 8'h00);
    chk(stack_top_pointer, MMP_SP_RESET);
    repeat (10) @(posedge core_clk);
    chk(8'(exp_q.size()), 8'h00);
    summarize();
  end
endmodule
